// ===== sac_pkg.sv
// package for the converter configuration and accumulator block
// assumes registers sit behind a 32-bit apb slave, one word per register
package sac_pkg;

    // register indices; byte address is four times the index
    localparam logic [7:0] IDX_ACC_CFG = 8'hba;
    localparam logic [7:0] IDX_CONV_CFG = 8'hbc;
    localparam logic [7:0] IDX_RES_LOW = 8'hbd;
    localparam logic [7:0] IDX_RES_HIGH = 8'hbe;
    localparam logic [7:0] IDX_CTRL = 8'hc0;
    localparam logic [7:0] IDX_STATUS = 8'hc1;

    // converter_config fields
    localparam int CC_DIV_MSB = 7;
    localparam int CC_DIV_LSB = 3;
    localparam int CC_EIGHT_BIT = 2;
    localparam int CC_TRACK = 1;
    localparam int CC_GAIN = 0;

    // accumulator_config fields
    localparam int AC_TWELVE = 7;
    localparam int AC_ACCUM = 6;
    localparam int AC_SJ_MSB = 5;
    localparam int AC_SJ_LSB = 3;
    localparam int AC_RPT_MSB = 2;
    localparam int AC_RPT_LSB = 0;

    // control register fields
    localparam int CT_ENABLE = 0;
    localparam int CT_BURST = 1;

    // reset values
    localparam logic [7:0] CONV_CFG_RST = 8'hf8;
    localparam logic [7:0] ACC_CFG_RST = 8'h00;
    localparam logic [1:0] CTRL_RST = 2'h0;
    localparam logic [15:0] ACC_RST = 16'h0000;

    // timing and format constants
    localparam int LPO_FREQ_MHZ = 20;
    localparam logic [1:0] TRACK_CYCLES = 2'h3;
    localparam logic [2:0] SJ_LEFT = 3'h4;

    // conversion sequence states, gray along idle-track-conv-next
    typedef enum logic [1:0] {
        SAC_IDLE = 2'b00,
        SAC_TRACK = 2'b01,
        SAC_CONV = 2'b11,
        SAC_NEXT = 2'b10
    } sac_state_t;

    // burst repeat code to number of conversions; reserved codes give one
    function automatic logic [6:0] sac_rpt_total(input logic [2:0] code);
        logic [6:0] n;
        n = 7'h01;
        case (code)
            3'h1: n = 7'h04;
            3'h2: n = 7'h08;
            3'h3: n = 7'h10;
            3'h4: n = 7'h20;
            3'h5: n = 7'h40;
            default: n = 7'h01;
        endcase
        return n;
    endfunction

endpackage

// ===== sac_clk_div.sv
// conversion clock divider: one tick per (div + 1) source ticks
// assumes src_tick is a one-cycle pulse on clk
`timescale 1ns/1ns
module sac_clk_div
    import sac_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic run,
    input wire logic src_tick,
    input wire logic [4:0] div,
    output logic tick_ff
);

    logic [4:0] cnt_ff;

    // count source ticks; restart whenever the sequence is idle
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_ff <= 5'h00;
            tick_ff <= 1'b0;
        end else if (!run) begin
            cnt_ff <= 5'h00;
            tick_ff <= 1'b0;
        end else if (src_tick && cnt_ff == div) begin
            cnt_ff <= 5'h00;
            tick_ff <= 1'b1;
        end else begin
            cnt_ff <= src_tick ? cnt_ff + 5'h01 : cnt_ff;
            tick_ff <= 1'b0;
        end
    end

    div_wrap_a: assert property (@(posedge clk) disable iff (rst)
        (run && src_tick && cnt_ff == div) |=> (tick_ff && cnt_ff == 5'h00))
        else $error("divider missed its terminal count");

    div_source_a: assert property (@(posedge clk) disable iff (rst)
        tick_ff |-> ($past(src_tick) && $past(cnt_ff) == $past(div)))
        else $error("conversion tick without a full source count");

endmodule

// ===== sac_top.sv
// converter configuration, sequencing and accumulator with apb registers
// assumes start_of_conv, conv_done and conv_result come from logic on clk;
// lpo_clk_in is the low-power oscillator pin and is synchronised here
`timescale 1ns/1ns

// Behaviour
// - conversion clock is source clock divided by divider field plus one.
// - source is system clock, or the 20 MHz oscillator in burst mode.
// - with 12-bit off, config bit 2 set selects 8-bit conversions, clear 10-bit.
// - delayed track waits 3 conversion clocks after start, else immediate.
// - config bit 0 selects amplifier gain one, clear gives one half.
// - accumulator config bit 7 enables 12-bit conversions.
// - outside burst, result holds latest conversion or running sum.
// - accumulate enable is write-only and always reads zero.
// - shift/justify code picks right shift 0-3 or left justify.
// - burst repeat code selects 1, 4, 8, 16, 32 or 64 summed conversions.
// - in burst, delayed track adds 3 conversion clocks before each conversion.
module sac_top
    import sac_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic lpo_clk_in,
    input wire logic start_of_conv,
    input wire logic conv_done,
    input wire logic [11:0] conv_result,
    output logic conversion_clock,
    output logic conv_start,
    output logic eight_bit_enable,
    output logic twelve_bit_enable,
    output logic amplifier_gain_select,
    output logic conv_complete
);

    logic [7:0] conv_cfg_ff;
    logic [7:0] acc_cfg_ff;
    logic accumulate_enable_ff;
    logic [1:0] ctrl_ff;
    logic [15:0] acc_ff;
    logic [31:0] prdata_ff;
    logic slverr_ff;
    logic [2:0] lpo_sync_ff;
    sac_state_t state_ff;
    sac_state_t nxt_state;
    logic [1:0] track_cnt_ff;
    logic [6:0] done_cnt_ff;
    logic conv_start_ff;
    logic complete_ff;
    logic burst_first_ff;

    logic setup_ph;
    logic wr_acc;
    logic [7:0] idx;
    logic hit;
    logic burst_mode_enable;
    logic delayed_track_select;
    logic [2:0] shift_justify_select;
    logic [6:0] rpt_total;
    logic lpo_edge;
    logic src_tick;
    logic conv_tick;
    logic go_conv;
    logic last_conv;
    logic [15:0] sample;
    logic [15:0] result_fmt;
    logic [4:0] lj_shift;

    // apb decode; printed offsets are indices, byte address is index times four
    assign idx = paddr[9:2];
    assign hit = (paddr[11:10] == 2'b00) && (paddr[1:0] == 2'b00) &&
                 (idx == IDX_ACC_CFG || idx == IDX_CONV_CFG || idx == IDX_RES_LOW ||
                  idx == IDX_RES_HIGH || idx == IDX_CTRL || idx == IDX_STATUS);
    assign setup_ph = psel && !penable;
    assign wr_acc = psel && penable && pwrite && hit;
    assign pready = 1'b1;
    assign prdata = prdata_ff;
    assign pslverr = psel && penable && slverr_ff;

    // field views
    assign burst_mode_enable = ctrl_ff[CT_BURST];
    assign delayed_track_select = conv_cfg_ff[CC_TRACK];
    assign shift_justify_select = acc_cfg_ff[AC_SJ_MSB:AC_SJ_LSB];
    assign rpt_total = sac_rpt_total(acc_cfg_ff[AC_RPT_MSB:AC_RPT_LSB]);
    assign eight_bit_enable = conv_cfg_ff[CC_EIGHT_BIT];
    assign twelve_bit_enable = acc_cfg_ff[AC_TWELVE];
    assign amplifier_gain_select = conv_cfg_ff[CC_GAIN];
    assign conv_start = conv_start_ff;
    assign conv_complete = complete_ff;
    assign conversion_clock = conv_tick;

    // oscillator pin synchroniser plus an edge flop behind it
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            lpo_sync_ff <= 3'h0;
        end else begin
            lpo_sync_ff <= {lpo_sync_ff[1:0], lpo_clk_in};
        end
    end
    assign lpo_edge = lpo_sync_ff[1] && !lpo_sync_ff[2];

    assign src_tick = burst_mode_enable ? lpo_edge : 1'b1;

    sac_clk_div u_div (
        .clk(clk),
        .rst(rst),
        .run(state_ff != SAC_IDLE),
        .src_tick(src_tick),
        .div(conv_cfg_ff[CC_DIV_MSB:CC_DIV_LSB]), // divide by field plus one
        .tick_ff(conv_tick)
    );

    // register writes on the access phase
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            conv_cfg_ff <= CONV_CFG_RST;
            acc_cfg_ff <= ACC_CFG_RST;
            ctrl_ff <= CTRL_RST;
        end else if (wr_acc) begin
            if (idx == IDX_CONV_CFG) begin
                conv_cfg_ff <= pwdata[7:0];
            end
            if (idx == IDX_ACC_CFG) begin
                acc_cfg_ff <= pwdata[7:0];
            end
            if (idx == IDX_CTRL) begin
                ctrl_ff <= pwdata[1:0];
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            accumulate_enable_ff <= 1'b0;
        end else if (wr_acc && idx == IDX_ACC_CFG) begin
            accumulate_enable_ff <= pwdata[AC_ACCUM];
        end
    end

    // sample masked to the chosen resolution
    always_comb begin
        sample = 16'h0000;
        lj_shift = 5'h06;
        if (twelve_bit_enable) begin
            sample = {4'h0, conv_result};
            lj_shift = 5'h04;
        end else if (eight_bit_enable) begin
            sample = {8'h00, conv_result[7:0]};
            lj_shift = 5'h08;
        end else begin
            sample = {6'h00, conv_result[9:0]};
        end
    end

    always_comb begin
        result_fmt = acc_ff;
        case (shift_justify_select)
            3'h1: result_fmt = acc_ff >> 1;
            3'h2: result_fmt = acc_ff >> 2;
            3'h3: result_fmt = acc_ff >> 3;
            SJ_LEFT: result_fmt = acc_ff << lj_shift;
            default: result_fmt = acc_ff;
        endcase
    end

    // read data captured in the setup phase, stable through access
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            prdata_ff <= 32'h0000_0000;
            slverr_ff <= 1'b0;
        end else if (setup_ph) begin
            slverr_ff <= !hit;
            prdata_ff <= 32'h0000_0000;
            if (!pwrite) begin
                case (idx)
                    IDX_ACC_CFG: prdata_ff <= {24'h00_0000, acc_cfg_ff[7], 1'b0, acc_cfg_ff[5:0]};
                    IDX_CONV_CFG: prdata_ff <= {24'h00_0000, conv_cfg_ff};
                    IDX_RES_LOW: prdata_ff <= {24'h00_0000, result_fmt[7:0]};
                    IDX_RES_HIGH: prdata_ff <= {24'h00_0000, result_fmt[15:8]};
                    IDX_CTRL: prdata_ff <= {30'h0000_0000, ctrl_ff};
                    IDX_STATUS: prdata_ff <= {29'h0000_0000, (state_ff != SAC_IDLE), state_ff};
                    default: prdata_ff <= 32'h0000_0000;
                endcase
            end
        end
    end

    assign last_conv = !burst_mode_enable || (done_cnt_ff + 7'h01 >= rpt_total);

    // sequence next state
    always_comb begin
        nxt_state = state_ff;
        go_conv = 1'b0;
        case (state_ff)
            SAC_IDLE: begin
                if (start_of_conv && ctrl_ff[CT_ENABLE]) begin
                    nxt_state = delayed_track_select ? SAC_TRACK : SAC_CONV;
                    go_conv = !delayed_track_select;
                end
            end
            SAC_TRACK: begin
                if (conv_tick && track_cnt_ff == TRACK_CYCLES - 2'h1) begin
                    nxt_state = SAC_CONV;
                    go_conv = 1'b1;
                end
            end
            SAC_CONV: begin
                if (conv_done) begin
                    nxt_state = last_conv ? SAC_IDLE : SAC_NEXT;
                end
            end
            SAC_NEXT: begin
                nxt_state = delayed_track_select ? SAC_TRACK : SAC_CONV;
                go_conv = !delayed_track_select;
            end
            default: nxt_state = SAC_IDLE;
        endcase
    end

    // sequence state, track counter and strobes
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_ff <= SAC_IDLE;
            track_cnt_ff <= 2'h0;
            conv_start_ff <= 1'b0;
            complete_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            conv_start_ff <= go_conv;
            complete_ff <= (state_ff == SAC_CONV) && conv_done && last_conv;
            if (state_ff == SAC_TRACK) begin
                track_cnt_ff <= conv_tick ? track_cnt_ff + 2'h1 : track_cnt_ff;
            end else begin
                track_cnt_ff <= 2'h0;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            done_cnt_ff <= 7'h00;
            burst_first_ff <= 1'b0;
        end else if (state_ff == SAC_IDLE) begin
            done_cnt_ff <= 7'h00;
            burst_first_ff <= 1'b1;
        end else if (state_ff == SAC_CONV && conv_done) begin
            done_cnt_ff <= done_cnt_ff + 7'h01;
            burst_first_ff <= 1'b0;
        end
    end

    // accumulator update; a finishing conversion wins over a software write
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            acc_ff <= ACC_RST;
        end else if (state_ff == SAC_CONV && conv_done) begin
            if (burst_mode_enable) begin
                acc_ff <= burst_first_ff ? sample : acc_ff + sample;
            end else begin
                acc_ff <= accumulate_enable_ff ? acc_ff + sample : sample;
            end
        end else if (wr_acc && idx == IDX_RES_LOW) begin
            acc_ff[7:0] <= pwdata[7:0];
        end else if (wr_acc && idx == IDX_RES_HIGH) begin
            acc_ff[15:8] <= pwdata[7:0];
        end
    end

    track_delay_a: assert property (@(posedge clk) disable iff (rst)
        (state_ff == SAC_IDLE && start_of_conv && ctrl_ff[CT_ENABLE] && !delayed_track_select)
        |=> (conv_start && state_ff == SAC_CONV))
        else $error("normal track did not start conversion at once");

    track_three_a: assert property (@(posedge clk) disable iff (rst)
        (conv_start && $past(state_ff) == SAC_TRACK) |-> ($past(track_cnt_ff) == 2'h2 && $past(conv_tick)))
        else $error("delayed track shorter or longer than three ticks");

    gain_select_a: assert property (@(posedge clk) disable iff (rst)
        $past(wr_acc && idx == IDX_CONV_CFG) |-> amplifier_gain_select == $past(pwdata[0]))
        else $error("gain select does not follow its bit");

    resolution_sel_a: assert property (@(posedge clk) disable iff (rst)
        $past(wr_acc && idx == IDX_CONV_CFG) |-> eight_bit_enable == $past(pwdata[2]))
        else $error("eight bit select does not follow its bit");

    twelve_sel_a: assert property (@(posedge clk) disable iff (rst)
        $past(wr_acc && idx == IDX_ACC_CFG) |-> twelve_bit_enable == $past(pwdata[7]))
        else $error("twelve bit select does not follow its bit");

    lpo_source_a: assert property (@(posedge clk) disable iff (rst)
        (conv_tick && burst_mode_enable && $past(burst_mode_enable)) |-> $past(lpo_edge))
        else $error("burst conversion clock not from the oscillator");

    accum_sum_a: assert property (@(posedge clk) disable iff (rst)
        (state_ff == SAC_CONV && conv_done && !burst_mode_enable && accumulate_enable_ff)
        |=> acc_ff == $past(acc_ff) + $past(sample))
        else $error("accumulator did not add the conversion");

    latest_only_a: assert property (@(posedge clk) disable iff (rst)
        (state_ff == SAC_CONV && conv_done && !burst_mode_enable && !accumulate_enable_ff)
        |=> acc_ff == $past(sample))
        else $error("result does not hold the latest conversion");

    read_ae_zero_a: assert property (@(posedge clk) disable iff (rst)
        (psel && penable && !pwrite && idx == IDX_ACC_CFG) |-> prdata[AC_ACCUM] == 1'b0)
        else $error("accumulate enable read back as one");

    ae_kept_a: assert property (@(posedge clk) disable iff (rst)
        (wr_acc && idx == IDX_ACC_CFG) |=> accumulate_enable_ff == $past(pwdata[AC_ACCUM]))
        else $error("accumulate enable not kept");

    shift_fmt_a: assert property (@(posedge clk) disable iff (rst)
        (shift_justify_select == 3'h2) |-> result_fmt == {2'b00, acc_ff[15:2]})
        else $error("shift by two format wrong");

    burst_count_a: assert property (@(posedge clk) disable iff (rst)
        (complete_ff && burst_mode_enable) |-> done_cnt_ff >= rpt_total)
        else $error("burst finished before its repeat count");

endmodule

// ===== sac_top_test.sv
// self-checking bench for the converter configuration and accumulator block
// assumes a zero-wait apb slave on a 250 MHz clock and a free 20 MHz oscillator pin
`timescale 1ns/1ns
module sac_top_test
    import sac_pkg::*;
;

`define CHK(nm, got, exp) \
    begin \
        n_compared++; \
        if ((got) !== (exp)) begin \
            n_errors++; \
            $display("CHECK FAILED %s expected %0h seen %0h", nm, exp, got); \
        end \
    end

    logic clk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic lpo_clk_in = 1'b0;
    logic start_of_conv = 1'b0;
    logic conv_done = 1'b0;
    logic [11:0] conv_result = 12'h000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic conversion_clock;
    logic conv_start;
    logic eight_bit_enable;
    logic twelve_bit_enable;
    logic amplifier_gain_select;
    logic conv_complete;
    int n_errors = 0;
    int n_compared = 0;
    int seed = 40117;
    logic [32:0] exp_q[$];
    string nm_q[$];
    logic [32:0] mon_e;
    string mon_s;
    logic [15:0] sum;
    logic [15:0] f;
    logic [11:0] r;
    int i;
    int c;
    int nt;
    int span;
    int gap;

    sac_top dut_u (
        .clk(clk),
        .rst(rst),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .prdata(prdata),
        .pready(pready),
        .pslverr(pslverr),
        .lpo_clk_in(lpo_clk_in),
        .start_of_conv(start_of_conv),
        .conv_done(conv_done),
        .conv_result(conv_result),
        .conversion_clock(conversion_clock),
        .conv_start(conv_start),
        .eight_bit_enable(eight_bit_enable),
        .twelve_bit_enable(twelve_bit_enable),
        .amplifier_gain_select(amplifier_gain_select),
        .conv_complete(conv_complete)
    );

    // system clock and an unrelated 20 MHz oscillator
    initial begin
        forever #2 clk = ~clk;
    end
    initial begin
        #3;
        forever #25 lpo_clk_in = ~lpo_clk_in;
    end

    // one apb transfer; a read notes its expected answer for the monitor
    task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] d, input logic [32:0] e,
                       input string nm);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= {2'b00, idx, 2'b00};
        pwdata <= d;
        if (!wr) begin
            exp_q.push_back(e);
            nm_q.push_back(nm);
        end
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) begin
            @(posedge clk);
        end
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] idx, input logic [31:0] d);
        apb(1'b1, idx, d, 33'h0_0000_0000, "");
    endtask

    task automatic rd(input logic [7:0] idx, input logic [7:0] d, input string nm);
        apb(1'b0, idx, 32'h0000_0000, {9'h000, 16'h0000, d}, nm);
    endtask

    // start pulse; returns just after the edge that takes it
    task automatic start_conv;
        @(posedge clk);
        start_of_conv <= 1'b1;
        @(posedge clk);
        start_of_conv <= 1'b0;
        #1;
    endtask

    // converter core answers with one result pulse
    task automatic finish_conv(input logic [11:0] v);
        @(posedge clk);
        conv_done <= 1'b1;
        conv_result <= v;
        @(posedge clk);
        conv_done <= 1'b0;
        #1;
    endtask

    // counts divided clock ticks until the converter is told to start
    task automatic wait_start(output int ticks, output int tspan, output int tgap);
        int k;
        int first;
        int last;
        k = 0;
        first = 0;
        last = 0;
        ticks = 0;
        while (conv_start !== 1'b1 && k < 1000) begin
            if (conversion_clock === 1'b1) begin
                if (ticks == 0) first = k;
                last = k;
                ticks++;
            end
            @(posedge clk);
            #1;
            k++;
        end
        tspan = last - first;
        tgap = k - last;
        `CHK("conv_start seen", conv_start, 1'b1)
    endtask

    // monitor: takes the oldest note when a read access completes
    always @(posedge clk) begin
        if (psel && penable && !pwrite && pready === 1'b1 && exp_q.size() > 0) begin
            mon_e = exp_q.pop_front();
            mon_s = nm_q.pop_front();
            `CHK(mon_s, {pslverr, prdata}, mon_e)
        end
    end

    task automatic final_report;
        $display("comparisons %0d mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // watchdog well beyond the expected few hundred cycles
    initial begin
        #100000;
        n_errors++;
        final_report();
    end

    initial begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        rd(IDX_CONV_CFG, 8'hf8, "conv cfg reset");
        rd(IDX_ACC_CFG, 8'h00, "acc cfg reset");
        wr(IDX_CONV_CFG, 32'h0000_0005);
        @(posedge clk);
        #1;
        `CHK("eight_bit_enable", eight_bit_enable, 1'b1)
        `CHK("amplifier_gain_select", amplifier_gain_select, 1'b1)
        rd(IDX_CONV_CFG, 8'h05, "conv cfg readback");
        wr(IDX_CONV_CFG, 32'h0000_0000);
        @(posedge clk);
        #1;
        `CHK("eight_bit_enable low", eight_bit_enable, 1'b0)
        `CHK("gain low", amplifier_gain_select, 1'b0)
        apb(1'b0, 8'hff, 32'h0000_0000, {1'b1, 32'h0000_0000}, "unmapped read");
        $display("test config done");
        // enable, burst off, repeat count kept zero
        wr(IDX_CTRL, 32'h0000_0001);
        wr(IDX_ACC_CFG, 32'h0000_00c0);
        @(posedge clk);
        #1;
        `CHK("twelve_bit_enable", twelve_bit_enable, 1'b1)
        rd(IDX_ACC_CFG, 8'h80, "accumulate bit reads zero");
        wr(IDX_RES_LOW, 32'h0000_0000);
        wr(IDX_RES_HIGH, 32'h0000_0000);
        sum = 16'h0000;
        for (i = 0; i < 3; i++) begin
            r = 12'($random(seed)) & 12'h3ff;
            start_conv();
            `CHK("conv_start normal", conv_start, 1'b1)
            finish_conv(r);
            `CHK("conv_complete", conv_complete, 1'b1)
            sum = sum + 16'(r);
        end
        rd(IDX_RES_LOW, sum[7:0], "sum low");
        rd(IDX_RES_HIGH, sum[15:8], "sum high");
        // shift and justify codes 0 to 4, then reserved code 5 last
        for (c = 0; c < 6; c++) begin
            wr(IDX_ACC_CFG, {24'h00_0000, 2'b10, c[2:0], 3'b000});
            f = (c < 4) ? (sum >> c) : ((c == 4) ? (sum << 4) : sum);
            rd(IDX_RES_LOW, f[7:0], "format low");
            rd(IDX_RES_HIGH, f[15:8], "format high");
        end
        // accumulate enable now clear: latest conversion only
        r = 12'($random(seed)) & 12'hfff;
        start_conv();
        finish_conv(r);
        rd(IDX_RES_LOW, r[7:0], "latest low");
        rd(IDX_RES_HIGH, {4'h0, r[11:8]}, "latest high");
        $display("test accumulate done");
        // narrow resolutions with left justify: ten bits, then eight
        wr(IDX_ACC_CFG, {24'h00_0000, 2'b00, SJ_LEFT, 3'b000});
        for (c = 0; c < 2; c++) begin
            wr(IDX_CONV_CFG, {29'h0000_0000, c[0], 2'b00});
            r = 12'($random(seed));
            f = (c == 1) ? {r[7:0], 8'h00} : {r[9:0], 6'h00};
            start_conv();
            `CHK("narrow conv_start", conv_start, 1'b1)
            finish_conv(r);
            rd(IDX_RES_LOW, f[7:0], "left justify low");
            rd(IDX_RES_HIGH, f[15:8], "left justify high");
        end
        $display("test narrow resolutions done");
        // delayed track with divider one
        wr(IDX_CONV_CFG, 32'h0000_000a);
        start_conv();
        wait_start(nt, span, gap);
        `CHK("track ticks", nt, 3)
        `CHK("tick span", span, 4)
        `CHK("start after third tick", gap, 1)
        finish_conv(12'h123);
        $display("test delayed track done");
        // burst of four conversions from the oscillator
        wr(IDX_CTRL, 32'h0000_0003);
        wr(IDX_ACC_CFG, 32'h0000_0081);
        sum = 16'h0000;
        start_conv();
        for (i = 0; i < 4; i++) begin
            wait_start(nt, span, gap);
            if (i == 0) begin
                `CHK("burst track ticks", nt, 3)
                `CHK("oscillator tick span", (span >= 48 && span <= 52), 1'b1)
            end
            r = 12'($random(seed)) & 12'hfff;
            sum = sum + 16'(r);
            finish_conv(r);
            `CHK("burst complete", conv_complete, (i == 3))
        end
        rd(IDX_RES_LOW, sum[7:0], "burst low");
        rd(IDX_RES_HIGH, sum[15:8], "burst high");
        $display("test burst done");
        repeat (2) @(posedge clk);
        #1;
        `CHK("reads answered", exp_q.size(), 0)
        final_report();
    end

endmodule
